// ---- bench/processor_state_mode_control_tb.sv ----
`timescale 1ns/1ps
`include "psm_defs.svh"

module processor_state_mode_control_tb import psm_pkg::*; ;
    logic sys_clk, rst, por_cmd, man_cmd, breq_cmd, por_n, man_n, breq;
    logic exc_req, exc_done, sleep_req, irq, er;
    logic [1:0] lag;
    logic [11:0] voff, off_r;
    logic [31:0] cur_pc, rd, vbr, bscv, pc_r;
    apb_req_s req;
    apb_rsp_s rsp;
    cpu_ctl_s ctl;
    int failures, tests_run, seed;

    processor_state_mode_control i_dut (
        .sys_clk_i(sys_clk), .rst_i(rst), .apb_i(req), .apb_o(rsp),
        .power_on_reset_n_i(por_n), .manual_reset_n_i(man_n),
        .bus_req_i(breq), .exc_req_i(exc_req), .exc_done_i(exc_done),
        .sleep_req_i(sleep_req), .cur_pc_i(cur_pc),
        .vec_offset_i(voff), .ctl_o(ctl), .irq_o(irq)
    );

    psm_far_side i_far (
        .sys_clk_i(sys_clk), .por_cmd_i(por_cmd), .man_cmd_i(man_cmd),
        .breq_cmd_i(breq_cmd), .lag_i(lag), .power_on_reset_n_o(por_n),
        .manual_reset_n_o(man_n), .bus_req_o(breq)
    );

    // ***********************************
    // checking and ending
    // ***********************************
    task automatic chk(input string what, input logic [31:0] exp, got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chb(input string what, input logic exp, got);
        chk(what, {31'h0, exp}, {31'h0, got});
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ***********************************
    // drivers
    // ***********************************
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge sys_clk);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= w;
        req.paddr <= a;
        req.pwdata <= d;
        @(posedge sys_clk);
        req.penable <= 1'b1;
        // read before this edge's updates land; only the watchdog ends it
        do begin
            @(posedge sys_clk);
        end while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        er = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic wait_st(input cpu_state_e s);
        int n;
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (ctl.state !== s && n < 100);
        chk("state", 32'(s), 32'(ctl.state));
    endtask

    task automatic wait_load;
        int n;
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (ctl.pc_load !== 1'b1 && n < 50);
        chb("pc load", 1'b1, ctl.pc_load);
        chb("mode on entry", 1'b1, ctl.privilege_mode_bit);
        chk("entry state", 32'(ST_EXCEPT), 32'(ctl.state));
    endtask

    task automatic take_exc(input logic [31:0] st);
        pc_r = $random(seed);
        off_r = 12'($random(seed));
        @(posedge sys_clk);
        exc_req <= 1'b1;
        cur_pc <= pc_r;
        voff <= off_r;
        wait_load();
        chk("vector", vbr + {20'h0, off_r}, ctl.pc);
        chk("saved pc", pc_r, ctl.saved_pc);
        chk("saved status", st, ctl.saved_status);
        @(posedge sys_clk);
        exc_req <= 1'b0;
        wait_st(ST_EXEC);
    endtask

    // ***********************************
    // clock, watchdog, stimulus
    // ***********************************
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // whole run is a few hundred cycles
    initial begin
        #500000;
        failures++;
        finish_test();
    end

    initial begin
        seed = 24631;
        failures = 0;
        tests_run = 0;
        rst = 1'b1;
        req = '0;
        {por_cmd, man_cmd, breq_cmd, lag} = 5'b10000;
        {exc_req, exc_done, sleep_req} = 3'b000;
        cur_pc = 32'h0;
        voff = 12'h0;
        vbr = `PSM_VBR_RST;
        repeat (16) @(posedge sys_clk);
        @(negedge sys_clk);
        chb("cpu rst", 1'b1, ctl.cpu_rst);
        chb("bsc rst", 1'b1, ctl.bsc_rst);
        @(posedge sys_clk);
        rst <= 1'b0;
        por_cmd <= 1'b0;
        wait_load();
        chk("reset pc", `PSM_RESET_VEC, ctl.pc);
        wait_st(ST_EXEC);
        apb(1'b0, `PSM_OFF_STATE, 32'h0);
        chk("state reg", 32'h1b, {27'h0, rd[4:0]});
        apb(1'b0, `PSM_OFF_SW, 32'h0);
        chk("status word", `PSM_SW_RST, rd);
        // random vector bases while privileged
        for (int i = 0; i < 3; i++) begin
            vbr = $random(seed);
            apb(1'b1, `PSM_OFF_VBR, vbr);
            chb("vbr write", 1'b0, er);
            take_exc(`PSM_SW_RST);
        end
        @(posedge sys_clk);
        exc_done <= 1'b1;
        @(posedge sys_clk);
        exc_done <= 1'b0;
        @(negedge sys_clk);
        chb("user mode", 1'b0, ctl.privilege_mode_bit);
        apb(1'b1, `PSM_OFF_VBR, ~vbr);
        chb("user write refused", 1'b1, er);
        apb(1'b0, `PSM_OFF_VBR, 32'h0);
        chk("vbr kept", vbr, rd);
        apb(1'b1, `PSM_OFF_IRQ_EN, 32'h10);
        @(negedge sys_clk);
        chb("irq raised", 1'b1, irq);
        apb(1'b1, `PSM_OFF_IRQ_CLR, 32'h10);
        repeat (2) @(negedge sys_clk);
        chb("irq cleared", 1'b0, irq);
        // reset-left and exception bits stay, violation bit cleared
        apb(1'b0, `PSM_OFF_IRQ_STAT, 32'h0);
        chk("irq status", 32'h3, rd);
        apb(1'b0, 12'h100, 32'h0);
        chk("unmapped", 32'h1, {31'h0, er} | rd);
        apb(1'b1, `PSM_OFF_SPC, 32'hffff_ffff);
        chb("ro write", 1'b1, er);
        take_exc(32'h0);
        // sleep then standby, woken by an exception
        for (int m = 0; m < 2; m++) begin
            apb(1'b1, `PSM_OFF_CTRL, {31'h0, m[0]});
            @(posedge sys_clk);
            sleep_req <= 1'b1;
            @(posedge sys_clk);
            sleep_req <= 1'b0;
            wait_st(ST_PDOWN);
            chb("halt", 1'b1, ctl.halt);
            chb("standby", m[0], ctl.standby);
            take_exc(`PSM_SW_RST);
        end
        @(posedge sys_clk);
        lag <= 2'($random(seed));
        breq_cmd <= 1'b1;
        wait_st(ST_BUSREL);
        chb("grant", 1'b1, ctl.bus_grant);
        @(posedge sys_clk);
        breq_cmd <= 1'b0;
        wait_st(ST_EXEC);
        chb("grant off", 1'b0, ctl.bus_grant);
        bscv = $random(seed);
        apb(1'b1, `PSM_OFF_BSC, bscv);
        @(posedge sys_clk);
        man_cmd <= 1'b1;
        wait_st(ST_RESET);
        chb("man cpu rst", 1'b1, ctl.periph_rst);
        chb("man bsc kept", 1'b0, ctl.bsc_rst);
        @(posedge sys_clk);
        man_cmd <= 1'b0;
        wait_load();
        chk("man pc", `PSM_RESET_VEC, ctl.pc);
        apb(1'b0, `PSM_OFF_BSC, 32'h0);
        chk("bsc after man", bscv, rd);
        apb(1'b0, `PSM_OFF_VBR, 32'h0);
        chk("vbr after man", `PSM_VBR_RST, rd);
        @(posedge sys_clk);
        {por_cmd, man_cmd} <= 2'b11;
        wait_st(ST_RESET);
        repeat (4) @(negedge sys_clk);
        chb("both bsc rst", 1'b1, ctl.bsc_rst);
        @(posedge sys_clk);
        {por_cmd, man_cmd} <= 2'b00;
        wait_load();
        wait_st(ST_EXEC);
        apb(1'b0, `PSM_OFF_BSC, 32'h0);
        chk("bsc after por", `PSM_BSC_RST, rd);
        apb(1'b0, `PSM_OFF_STATE, 32'h0);
        chb("por kind", 1'b1, rd[3]);
        finish_test();
    end
endmodule

// ---- bench/psm_far_side.sv ----
`timescale 1ns/1ps

// ***********************************
// reset sources and bus requester
// ***********************************
module psm_far_side (
    // clock
    input wire logic sys_clk_i,
    // commands from the bench
    input wire logic por_cmd_i,
    input wire logic man_cmd_i,
    input wire logic breq_cmd_i,
    input wire logic [1:0] lag_i,
    // pins towards the device
    output logic power_on_reset_n_o,
    output logic manual_reset_n_o,
    output logic bus_req_o
);
    // lag 0..3 gives 1..4 cycles of delay: pins answer promptly or slowly
    logic [2:0] hist [0:3] = '{default: 3'b100};

    always @(posedge sys_clk_i) begin
        hist[0] <= {por_cmd_i, man_cmd_i, breq_cmd_i};
        for (int i = 1; i < 4; i++) begin
            hist[i] <= hist[i-1];
        end
    end

    // reset pins are active low levels
    assign power_on_reset_n_o = ~hist[lag_i][2];
    assign manual_reset_n_o = ~hist[lag_i][1];
    assign bus_req_o = hist[lag_i][0];
endmodule

// ---- design/processor_state_mode_control.sv ----
`timescale 1ns/1ps
`include "psm_defs.svh"

// Operation
// RULE1 - five states: reset, exception, bus released, execute, power down
// RULE2 - power-on reset pin low holds the cpu in power-on reset
// RULE3 - manual reset pin low holds the cpu in manual reset
// RULE4 - power-on reset clears cpu state and every module register
// RULE5 - manual reset clears everything except bus controller registers
// RULE6 - exception state is transient, entered on reset, exception, interrupt
// RULE7 - leaving reset loads pc with the fixed reset address
// RULE8 - exception saves pc and status word into saved copies
// RULE9 - exception then branches to vector base plus vector offset
// RULE10 - mode bit 0 means user mode, 1 means privileged mode
// RULE11 - entering reset or exception state forces mode bit to 1
// RULE12 - end of exception handling clears mode bit to 0
// RULE13 - some registers writable only while privileged mode is active
// RULE14 - power down halts execution, with sleep and standby variants
// RULE15 - bus released state hands the bus away, no own cycles
// RULE16 - power-on reset wins when both reset pins are low
module processor_state_mode_control
    import psm_pkg::*;
#(
    parameter int VOFF_W = `PSM_VOFF_W
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // register bus
    input wire apb_req_s apb_i,
    output apb_rsp_s apb_o,
    // pins from outside
    input wire logic power_on_reset_n_i,
    input wire logic manual_reset_n_i,
    input wire logic bus_req_i,
    // core side
    input wire logic exc_req_i,
    input wire logic exc_done_i,
    input wire logic sleep_req_i,
    input wire logic [31:0] cur_pc_i,
    input wire logic [VOFF_W-1:0] vec_offset_i,
    output cpu_ctl_s ctl_o,
    output logic irq_o
);

    // ***********************************
    // state
    // ***********************************
    typedef struct packed {
        logic [2:0][2:0] sync;
        logic [2:0] lvl;
        cpu_state_e st;
        logic por_kind;
        logic [31:0] status_word;
        logic [31:0] vbr;
        logic [31:0] saved_pc;
        logic [31:0] saved_status;
        logic [31:0] bsc_cfg;
        logic [31:0] pc;
        logic pc_load;
        logic stby_sel;
        logic [`PSM_EV_W-1:0] ev_stat;
        logic [`PSM_EV_W-1:0] ev_en;
        logic irq;
        logic halt;
        logic stby;
        logic grant;
        logic cpu_rst;
        logic bsc_rst;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } psm_state_s;

    psm_state_s s;
    psm_state_s next_s;

    logic [2:0] pins;
    logic acc;
    logic first;
    logic wr_go;
    logic prot;
    logic mapped;
    logic ro;
    logic [31:0] rd;
    logic [`PSM_EV_W-1:0] ev;
    logic [`PSM_EV_W-1:0] clr;
    logic in_rst;
    logic md;

    assign md = s.status_word[`PSM_MD_BIT];

    // ***********************************
    // next state
    // ***********************************
    always_comb begin
        next_s = s;
        next_s.pc_load = 1'b0;
        next_s.pready = 1'b0;
        next_s.pslverr = 1'b0;
        ev = '0;
        clr = '0;
        in_rst = 1'b0;
        rd = '0;
        mapped = 1'b1;
        ro = 1'b0;
        pins = {bus_req_i, manual_reset_n_i, power_on_reset_n_i};

        // first stage feeds only the second; level moves on agreement
        for (int i = 0; i < 3; i++) begin
            next_s.sync[i] = {s.sync[i][1:0], pins[i]};
            if (s.sync[i][1] == s.sync[i][2]) begin
                next_s.lvl[i] = s.sync[i][2];
            end
        end

        // register access: answer one cycle into the access phase
        acc = apb_i.psel & apb_i.penable;
        first = acc & ~s.pready;
        wr_go = acc & s.pready & apb_i.pwrite & ~s.pslverr;
        prot = (apb_i.paddr == `PSM_OFF_SW) ||
               (apb_i.paddr == `PSM_OFF_VBR) ||
               (apb_i.paddr == `PSM_OFF_BSC);
        case (apb_i.paddr)
            `PSM_OFF_CTRL: rd[`PSM_CTRL_STBY] = s.stby_sel;
            `PSM_OFF_SW: rd = s.status_word;
            `PSM_OFF_VBR: rd = s.vbr;
            `PSM_OFF_SPC: begin
                rd = s.saved_pc;
                ro = 1'b1;
            end
            `PSM_OFF_SSR: begin
                rd = s.saved_status;
                ro = 1'b1;
            end
            `PSM_OFF_STATE: begin
                rd[2:0] = s.st;
                rd[`PSM_STATE_KIND_BIT] = s.por_kind;
                rd[`PSM_STATE_MD_BIT] = md;
                ro = 1'b1;
            end
            `PSM_OFF_IRQ_STAT: begin
                rd[`PSM_EV_W-1:0] = s.ev_stat;
                ro = 1'b1;
            end
            `PSM_OFF_IRQ_CLR: rd = '0;
            `PSM_OFF_IRQ_EN: rd[`PSM_EV_W-1:0] = s.ev_en;
            `PSM_OFF_BSC: rd = s.bsc_cfg;
            default: mapped = 1'b0;
        endcase
        if (first) begin
            next_s.pready = 1'b1;
            next_s.prdata = mapped ? rd : '0;
            next_s.pslverr = ~mapped | (apb_i.pwrite & ro);
            // user mode may not write these
            if (apb_i.pwrite && prot && !md) begin  // [RULE13]
                next_s.pslverr = 1'b1;
                ev[`PSM_EV_PRIV] = 1'b1;
            end
        end
        if (wr_go) begin
            case (apb_i.paddr)
                `PSM_OFF_CTRL:
                    next_s.stby_sel = apb_i.pwdata[`PSM_CTRL_STBY];
                `PSM_OFF_SW: next_s.status_word = apb_i.pwdata;
                `PSM_OFF_VBR: next_s.vbr = apb_i.pwdata;
                `PSM_OFF_IRQ_CLR: clr = apb_i.pwdata[`PSM_EV_W-1:0];
                `PSM_OFF_IRQ_EN: next_s.ev_en = apb_i.pwdata[`PSM_EV_W-1:0];
                `PSM_OFF_BSC: next_s.bsc_cfg = apb_i.pwdata;
                default: next_s.stby_sel = s.stby_sel;
            endcase
        end

        // processor state flow; power-on checked first
        if (!s.lvl[`PSM_PIN_POR]) begin  // [RULE2] [RULE16]
            in_rst = 1'b1;
            next_s.st = ST_RESET;
            next_s.por_kind = 1'b1;
            next_s.bsc_cfg = `PSM_BSC_RST;  // [RULE4]
        end else if (!s.lvl[`PSM_PIN_MAN]) begin  // [RULE3]
            in_rst = 1'b1;
            next_s.st = ST_RESET;
            next_s.por_kind = 1'b0;  // [RULE5]
        end
        if (in_rst) begin  // [RULE4] [RULE5]
            next_s.status_word = `PSM_SW_RST;  // [RULE11]
            next_s.vbr = `PSM_VBR_RST;
            next_s.saved_pc = '0;
            next_s.saved_status = '0;
            next_s.pc = '0;
            next_s.stby_sel = 1'b0;
            next_s.ev_en = '0;
        end else begin
            case (s.st)  // [RULE1]
                ST_RESET: begin
                    // fixed fetch address, no vector base involved
                    next_s.st = ST_EXCEPT;  // [RULE6]
                    next_s.pc = `PSM_RESET_VEC;  // [RULE7]
                    // a late status write must not leave user mode here
                    next_s.status_word[`PSM_MD_BIT] = 1'b1;  // [RULE11]
                    next_s.pc_load = 1'b1;
                    ev[`PSM_EV_RESET] = 1'b1;
                end
                ST_EXCEPT: next_s.st = ST_EXEC;  // [RULE6]
                ST_EXEC: begin
                    if (exc_req_i) begin
                        next_s.st = ST_EXCEPT;  // [RULE6]
                    end else if (exc_done_i) begin
                        next_s.status_word[`PSM_MD_BIT] = 1'b0;  // [RULE12]
                    end else if (s.lvl[`PSM_PIN_BREQ]) begin
                        next_s.st = ST_BUSREL;  // [RULE15]
                        ev[`PSM_EV_BUSREL] = 1'b1;
                    end else if (sleep_req_i) begin
                        next_s.st = ST_PDOWN;  // [RULE14]
                        ev[`PSM_EV_PDOWN] = 1'b1;
                    end
                end
                ST_BUSREL: begin
                    // bus owner finishes first; pending events wait
                    if (!s.lvl[`PSM_PIN_BREQ]) begin
                        next_s.st = ST_EXEC;  // [RULE15]
                    end
                end
                ST_PDOWN: begin
                    if (exc_req_i) begin
                        next_s.st = ST_EXCEPT;  // [RULE6]
                    end
                end
                default: next_s.st = ST_RESET;
            endcase
            if (next_s.st == ST_EXCEPT && s.st != ST_RESET) begin
                next_s.saved_pc = cur_pc_i;  // [RULE8]
                next_s.saved_status = s.status_word;  // [RULE8]
                next_s.status_word[`PSM_MD_BIT] = 1'b1;  // [RULE11]
                next_s.pc = s.vbr + 32'(vec_offset_i);  // [RULE9]
                next_s.pc_load = 1'b1;
                ev[`PSM_EV_EXC] = 1'b1;
            end
        end

        // sticky events: a set in the clear cycle survives
        if (in_rst) begin
            next_s.ev_stat = '0;
        end else begin
            next_s.ev_stat = (s.ev_stat & ~clr) | ev;
        end
        next_s.irq = |(next_s.ev_stat & next_s.ev_en);

        // registered copies so every output leaves a flop
        next_s.halt = (next_s.st == ST_PDOWN);  // [RULE14]
        next_s.stby = (next_s.st == ST_PDOWN) & next_s.stby_sel;
        next_s.grant = (next_s.st == ST_BUSREL);  // [RULE15]
        next_s.cpu_rst = (next_s.st == ST_RESET);
        next_s.bsc_rst = (next_s.st == ST_RESET) & next_s.por_kind;
    end

    // ***********************************
    // registers
    // ***********************************
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s <= '0;
            s.status_word <= `PSM_SW_RST;
            s.por_kind <= 1'b1;
            s.cpu_rst <= 1'b1;
            s.bsc_rst <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // ***********************************
    // outputs
    // ***********************************
    assign apb_o.prdata = s.prdata;
    assign apb_o.pready = s.pready;
    assign apb_o.pslverr = s.pslverr;
    assign ctl_o.state = s.st;
    assign ctl_o.privilege_mode_bit = s.status_word[`PSM_MD_BIT];  // [RULE10]
    assign ctl_o.pc_load = s.pc_load;
    assign ctl_o.pc = s.pc;
    assign ctl_o.saved_pc = s.saved_pc;
    assign ctl_o.saved_status = s.saved_status;
    assign ctl_o.halt = s.halt;
    assign ctl_o.standby = s.stby;
    assign ctl_o.bus_grant = s.grant;
    assign ctl_o.cpu_rst = s.cpu_rst;
    assign ctl_o.periph_rst = s.cpu_rst;
    assign ctl_o.bsc_rst = s.bsc_rst;
    assign irq_o = s.irq;

    // ***********************************
    // checks
    // ***********************************
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);

    logic run_ok;
    assign run_ok = s.lvl[`PSM_PIN_POR] & s.lvl[`PSM_PIN_MAN];

    state_legal_a: assert property (  // [RULE1]
        s.st inside {ST_RESET, ST_EXCEPT, ST_BUSREL, ST_EXEC, ST_PDOWN})
        else $error("illegal processor state");

    por_hold_a: assert property (  // [RULE2]
        !s.lvl[`PSM_PIN_POR] |=> s.st == ST_RESET && s.por_kind
        && s.bsc_rst)
        else $error("power-on reset not held");

    man_hold_a: assert property (  // [RULE3]
        s.lvl[`PSM_PIN_POR] && !s.lvl[`PSM_PIN_MAN]
        |=> s.st == ST_RESET && !s.por_kind && !s.bsc_rst)
        else $error("manual reset not held");

    por_init_a: assert property (  // [RULE4]
        !s.lvl[`PSM_PIN_POR] |=> s.bsc_cfg == `PSM_BSC_RST
        && s.vbr == `PSM_VBR_RST && s.ev_en == '0)
        else $error("power-on reset left state");

    bsc_keep_a: assert property (  // [RULE5]
        s.lvl[`PSM_PIN_POR] && !s.lvl[`PSM_PIN_MAN]
        |=> s.bsc_cfg == $past(s.bsc_cfg) && s.vbr == `PSM_VBR_RST)
        else $error("manual reset disturbed bus controller");

    exc_short_a: assert property (  // [RULE6]
        s.st == ST_EXCEPT && run_ok |=> s.st == ST_EXEC)
        else $error("exception state not transient");

    reset_vec_a: assert property (  // [RULE7]
        s.st == ST_RESET && run_ok |=> s.st == ST_EXCEPT
        && s.pc_load && s.pc == `PSM_RESET_VEC ##1 s.st == ST_EXEC)
        else $error("reset fetch address wrong");

    save_ctx_a: assert property (  // [RULE8]
        s.st == ST_EXEC && run_ok && exc_req_i
        |=> s.saved_pc == $past(cur_pc_i)
        && s.saved_status == $past(s.status_word))
        else $error("context not saved");

    vector_a: assert property (  // [RULE9]
        s.st inside {ST_EXEC, ST_PDOWN} && run_ok && exc_req_i
        |=> s.pc_load && s.pc == $past(s.vbr) + 32'($past(vec_offset_i)))
        else $error("handler address wrong");

    priv_grant_a: assert property (  // [RULE10]
        first && apb_i.pwrite && prot && md |=> s.pready && !s.pslverr)
        else $error("privileged write refused");

    md_entry_a: assert property (  // [RULE11]
        s.st inside {ST_RESET, ST_EXCEPT} |-> md)
        else $error("mode bit low in reset or exception");

    md_exit_a: assert property (  // [RULE12]
        s.st == ST_EXEC && run_ok && !exc_req_i && exc_done_i
        |=> !md ##1 !md || s.st != ST_EXEC || $past(wr_go))
        else $error("mode bit not cleared at return");

    priv_a: assert property (  // [RULE13]
        first && apb_i.pwrite && prot && !md
        |=> s.pslverr && s.pready ##1 s.vbr == $past(s.vbr, 2)
        || !run_ok)
        else $error("user mode write not refused");

    halt_a: assert property (  // [RULE14]
        s.st == ST_EXEC && run_ok && !exc_req_i && !exc_done_i
        && !s.lvl[`PSM_PIN_BREQ] && sleep_req_i
        |=> s.halt && s.stby == s.stby_sel)
        else $error("power down did not halt");

    busrel_a: assert property (  // [RULE15]
        s.st == ST_BUSREL |-> s.grant && !s.pc_load)
        else $error("bus not released");

    por_prio_a: assert property (  // [RULE16]
        !s.lvl[`PSM_PIN_POR] && !s.lvl[`PSM_PIN_MAN] |=> s.por_kind)
        else $error("manual reset beat power-on reset");

endmodule

// ---- design/psm_defs.svh ----
`ifndef PSM_DEFS_SVH
`define PSM_DEFS_SVH

// ***********************************
// address map and field layout
// ***********************************
`define PSM_ADDR_W 12
`define PSM_OFF_CTRL 12'h000
`define PSM_OFF_SW 12'h004
`define PSM_OFF_VBR 12'h008
`define PSM_OFF_SPC 12'h00c
`define PSM_OFF_SSR 12'h010
`define PSM_OFF_STATE 12'h014
`define PSM_OFF_IRQ_STAT 12'h018
`define PSM_OFF_IRQ_CLR 12'h01c
`define PSM_OFF_IRQ_EN 12'h020
`define PSM_OFF_BSC 12'h024
`define PSM_CTRL_STBY 0
`define PSM_MD_BIT 30
`define PSM_STATE_KIND_BIT 3
`define PSM_STATE_MD_BIT 4

// ***********************************
// reset values and constants
// ***********************************
`define PSM_RESET_VEC 32'ha000_0000
`define PSM_SW_RST 32'h4000_0000
`define PSM_VBR_RST 32'h0000_0000
`define PSM_BSC_RST 32'h0000_0000
`define PSM_VOFF_W 12

// ***********************************
// event bits
// ***********************************
`define PSM_EV_W 5
`define PSM_EV_RESET 0
`define PSM_EV_EXC 1
`define PSM_EV_BUSREL 2
`define PSM_EV_PDOWN 3
`define PSM_EV_PRIV 4

// ***********************************
// pin synchroniser slots
// ***********************************
`define PSM_PIN_POR 0
`define PSM_PIN_MAN 1
`define PSM_PIN_BREQ 2

`endif

// ---- design/psm_pkg.sv ----
`include "psm_defs.svh"

package psm_pkg;

    // ***********************************
    // processor states
    // ***********************************
    typedef enum logic [2:0] {
        ST_RESET = 3'b000,
        ST_EXCEPT = 3'b001,
        ST_BUSREL = 3'b010,
        ST_EXEC = 3'b011,
        ST_PDOWN = 3'b100
    } cpu_state_e;

    // ***********************************
    // apb carriers
    // ***********************************
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [`PSM_ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_s;

    // ***********************************
    // control outputs to the core
    // ***********************************
    typedef struct packed {
        cpu_state_e state;
        logic privilege_mode_bit;
        logic pc_load;
        logic [31:0] pc;
        logic [31:0] saved_pc;
        logic [31:0] saved_status;
        logic halt;
        logic standby;
        logic bus_grant;
        logic cpu_rst;
        logic periph_rst;
        logic bsc_rst;
    } cpu_ctl_s;

endpackage
